// ### common/mtf_pkg.sv
package mtf_pkg;
    // address mark and fill bytes
    localparam logic [7:0] MARK_BYTE = 8'hA1;
    localparam logic [7:0] ID_MARK_BYTE = 8'hFE;
    localparam logic [7:0] DATA_MARK_BYTE = 8'hF8;
    localparam logic [7:0] GAP_FILL = 8'h4E;
    localparam logic [7:0] SYNC_FILL = 8'h00;
    // check generator x^16 + x^12 + x^9 + 1, preset all ones
    localparam logic [15:0] CRC_POLY = 16'h1201;
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    // default field lengths in bytes
    localparam int GAP1_LEN = 16;
    localparam int GAP1_MIN = 12;
    localparam int GAP2_LEN = 16;
    localparam int GAP3_LEN = 32;
    localparam int SYNC_LEN = 12;
    localparam int SECTOR_LEN = 512;
    localparam int SECTOR_CNT = 17;
    // bit cell timing: 5 Mbit/s data, 10 MHz half-cells
    localparam int CLK_HZ = 40000000;
    localparam int CELL_HZ = 10000000;
    localparam int CELL_CYC = CLK_HZ / CELL_HZ;
    // sector id carried to the formatter
    typedef struct packed {
        logic [7:0] cyl_hi;
        logic [7:0] cyl_lo;
        logic [7:0] head;
        logic [7:0] sector;
    } mtf_id_type;
    // sequence positions
    typedef enum logic [3:0] {
        ST_IDLE, ST_WAIT_IDX, ST_GAP1, ST_SYNC, ST_MARK, ST_KIND,
        ST_BODY, ST_CRC, ST_GAP2, ST_GAP3, ST_GAP4
    } mtf_state_type;
endpackage : mtf_pkg

// ### rtl/mtf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module mtf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // storage
    logic [AW:0] wr_ptr;  // write pointer with wrap bit
    logic [AW:0] rd_ptr;  // read pointer with wrap bit
    logic push;
    logic pop;
    assign o_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign o_valid = wr_ptr != rd_ptr;
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem[rd_ptr[AW-1:0]];
    // storage write, no reset needed
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end
    // pointers
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule : mtf_fifo
`default_nettype wire

// ### rtl/mtf_formatter.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - each sector opens with cylinder/head/sector id
// - data field follows its id field
// - every bit leaves as mfm clock/data cells
// - both fields open with A1 mark byte
// - second mark byte says id or data
// - one clock bit dropped in A1 byte
// - fields end with x16+x12+x9+1 check
// - gap one defaults 16, never below 12
// - sync field sits between gap one, first id
// - gap two ends in sync before data mark
// - gap two long enough for pll lock
// - gap three after each data field
// - format runs index to next index
// - gap four fills until the index
module mtf_formatter import mtf_pkg::*; #(
    parameter int GAP1 = GAP1_LEN,
    parameter int GAP2 = GAP2_LEN,
    parameter int GAP3 = GAP3_LEN,
    parameter int SYNC = SYNC_LEN,
    parameter int BODY = SECTOR_LEN,
    parameter int SECTORS = SECTOR_CNT
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // command
    input wire logic i_start,
    input wire mtf_id_type i_id,
    output logic o_busy,
    output logic o_done,
    // payload stream
    input wire logic i_pay_valid,
    input wire logic [7:0] i_pay_data,
    output logic o_pay_ready,
    // drive pins
    input wire logic i_index,
    output logic o_write_gate,
    output logic o_write_data
);
    localparam int CW = 16;
    localparam logic [1:0] CELL_LAST = 2'(CELL_CYC - 1);
    localparam int GAP1_USE = (GAP1 < GAP1_MIN) ? GAP1_MIN : GAP1;

    mtf_state_type state;  // sequence position
    logic [CW-1:0] cnt;  // bytes left in current field
    logic is_data;  // field is data rather than id
    logic [7:0] sec_no;  // sector being written
    logic [15:0] crc;  // running check
    logic [7:0] cur;  // byte being sent
    logic cur_mark;  // current byte is the special mark
    logic [15:0] shreg;  // clock/data cells of current byte
    logic [3:0] bit_left;  // cells left in shift register
    logic [1:0] cell_div;  // half-cell divider
    logic cell_en;  // one pulse per half-cell
    logic last_bit;  // previous data bit for clock rule
    logic byte_take;  // next byte loaded this cell
    logic idx_s1, idx_s2, idx_d;  // index synchroniser
    logic idx_rise;
    logic [7:0] next_byte;
    logic next_mark;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_take;

    // payload buffer decouples source from bit timing
    mtf_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .i_valid(i_pay_valid), .i_data(i_pay_data), .o_ready(o_pay_ready),
        .o_valid(fifo_valid), .o_data(fifo_data), .i_ready(fifo_take)
    );

    // index pin synchroniser; the edge is taken from the second and third stages
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            idx_s1 <= 1'b0;
            idx_s2 <= 1'b0;
            idx_d <= 1'b0;
        end else begin
            idx_s1 <= i_index;
            idx_s2 <= idx_s1;
            idx_d <= idx_s2;
        end
    end
    assign idx_rise = idx_s2 && !idx_d;

    // half-cell enable from the reference clock; parked on its last count
    // while the gate is low, so the first cell starts right with the gate
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) cell_div <= '0;
        else if (!o_write_gate) cell_div <= CELL_LAST;
        else cell_div <= (cell_div == CELL_LAST) ? 2'h0 : cell_div + 2'h1;
    end
    assign cell_en = cell_div == CELL_LAST;
    assign byte_take = cell_en && bit_left == 4'h0 && o_write_gate;

    // byte source for the current field
    always_comb begin
        next_mark = 1'b0;
        unique case (state)
            ST_GAP1, ST_GAP2, ST_GAP3, ST_GAP4: next_byte = GAP_FILL;
            ST_SYNC: next_byte = SYNC_FILL;
            ST_MARK: begin
                next_byte = MARK_BYTE;
                next_mark = 1'b1;
            end
            ST_KIND:
                next_byte = is_data ? DATA_MARK_BYTE : ID_MARK_BYTE;
            ST_BODY: begin
                if (is_data) next_byte = fifo_data;
                else begin
                    // counter runs 4 down to 1, cylinder goes out first
                    unique case (cnt[1:0])
                        2'h0: next_byte = i_id.cyl_hi;
                        2'h3: next_byte = i_id.cyl_lo;
                        2'h2: next_byte = i_id.head;
                        2'h1: next_byte = sec_no;
                    endcase
                end
            end
            // check register shifts after each byte: its head is next
            ST_CRC: next_byte = crc[15:8];
            default: next_byte = GAP_FILL;
        endcase
    end
    // a data byte is consumed only when it is actually sent; an empty
    // buffer would corrupt the field, so the source must keep it fed
    assign fifo_take = byte_take && state == ST_BODY && is_data;

    // field sequencer
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
            cnt <= '0;
            is_data <= 1'b0;
            sec_no <= 8'h00;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (state == ST_IDLE) begin
                if (i_start) state <= ST_WAIT_IDX;
            end else if (state == ST_WAIT_IDX) begin
                if (idx_rise) begin
                    state <= ST_GAP1;
                    cnt <= CW'(GAP1_USE);
                    sec_no <= 8'h00;
                    is_data <= 1'b0;
                end
            end else if (idx_rise) begin
                state <= ST_IDLE;
                o_done <= 1'b1;
            end else if (byte_take) begin
                if (cnt > CW'(1)) cnt <= cnt - CW'(1);
                else begin
                    unique case (state)
                        ST_GAP1, ST_GAP2: begin
                            state <= ST_SYNC;
                            cnt <= CW'(SYNC);
                        end
                        ST_GAP3: begin
                            is_data <= 1'b0;
                            if (sec_no == 8'(SECTORS)) begin
                                state <= ST_GAP4;
                            end else begin
                                state <= ST_SYNC;
                                cnt <= CW'(SYNC);
                            end
                        end
                        ST_SYNC: state <= ST_MARK;
                        ST_MARK: state <= ST_KIND;
                        ST_KIND: begin
                            state <= ST_BODY;
                            cnt <= is_data ? CW'(BODY) : CW'(4);
                        end
                        ST_BODY: begin
                            state <= ST_CRC;
                            cnt <= CW'(2);
                        end
                        ST_CRC: begin
                            if (is_data) begin
                                state <= ST_GAP3;
                                cnt <= CW'(GAP3);
                                sec_no <= sec_no + 8'h01;
                            end else begin
                                state <= ST_GAP2;
                                cnt <= CW'(GAP2);
                                is_data <= 1'b1;
                            end
                        end
                        default: cnt <= CW'(1);  // gap four runs on
                    endcase
                end
            end
        end
    end

    // check accumulates from the mark through the body
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) crc <= CRC_PRESET;
        else if (byte_take) begin
            if (state == ST_SYNC) crc <= CRC_PRESET;
            else if (state == ST_MARK || state == ST_KIND || state == ST_BODY)
                crc <= crc_byte(crc, next_byte);
            else if (state == ST_CRC) crc <= {crc[7:0], 8'h00};
        end
    end

    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_byte

    // mfm encoder: clock cell is 1 only between two zero data bits
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            shreg <= '0;
            bit_left <= '0;
            last_bit <= 1'b0;
            cur <= 8'h00;
            cur_mark <= 1'b0;
        end else if (!o_write_gate) begin
            // cleared so no stale cell leaks out when the gate rises
            shreg <= '0;
            bit_left <= '0;
            last_bit <= 1'b0;
        end else if (cell_en) begin
            if (bit_left == 4'h0) begin
                cur <= next_byte;
                cur_mark <= next_mark;
                shreg <= mfm_cells(next_byte, last_bit, next_mark);
                last_bit <= next_byte[0];
                bit_left <= 4'hF;
            end else begin
                shreg <= {shreg[14:0], 1'b0};
                bit_left <= bit_left - 4'h1;
            end
        end
    end

    function automatic logic [15:0] mfm_cells(input logic [7:0] d,
                                              input logic prev,
                                              input logic mark);
        logic [15:0] r;
        logic p;
        r = '0;
        p = prev;
        for (int i = 7; i >= 0; i--) begin
            r[2*i+1] = !p && !d[i];
            r[2*i] = d[i];
            p = d[i];
        end
        // the clock between data bits 4 and 5 (msb first) is dropped
        if (mark) r[5] = 1'b0;
        return r;
    endfunction : mfm_cells

    // write gate is high from the first index until the next
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) o_write_gate <= 1'b0;
        else o_write_gate <= state != ST_IDLE && state != ST_WAIT_IDX
                             && !(idx_rise);
    end

    // serial output is registered from the shift register head, forced low while the gate is low
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) o_write_data <= 1'b0;
        else o_write_data <= o_write_gate && shreg[15];
    end

    assign o_busy = state != ST_IDLE;

    // checks
    property p_mark_drop;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (cell_en && bit_left == 4'h0 && o_write_gate && next_mark)
            |=> shreg == 16'h4489;
    endproperty
    a_mark_drop: assert property (p_mark_drop) else $error("bad mark");
    property p_gate_idle;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state == ST_IDLE) |=> !o_write_gate;
    endproperty
    a_gate_idle: assert property (p_gate_idle) else $error("gate on");
    property p_gap1;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state == ST_WAIT_IDX && idx_rise) |=> cnt >= CW'(GAP1_MIN);
    endproperty
    a_gap1: assert property (p_gap1) else $error("gap one short");
    property p_after_id;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state == ST_CRC && !is_data && $past(state) == ST_CRC)
            ##0 (byte_take && cnt == CW'(1)) |=> state == ST_GAP2;
    endproperty
    a_after_id: assert property (p_after_id) else $error("no gap2");
    property p_kind;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (byte_take && state == ST_KIND) |=> cur == (is_data ? DATA_MARK_BYTE
                                                           : ID_MARK_BYTE);
    endproperty
    a_kind: assert property (p_kind) else $error("bad kind");
    property p_cells;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (bit_left == 4'hF && o_write_gate)
            |-> shreg[14] == cur[7] && (shreg == 16'h4489) == cur_mark;
    endproperty
    a_cells: assert property (p_cells) else $error("bad cells");
    property p_preset;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state == ST_SYNC && byte_take) |=> crc == CRC_PRESET;
    endproperty
    a_preset: assert property (p_preset) else $error("no preset");
    property p_done_idx;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        o_done |-> $past(idx_rise) && state == ST_IDLE;
    endproperty
    a_done_idx: assert property (p_done_idx) else $error("bad end");
    property p_gap3;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        (state == ST_CRC && is_data && byte_take && cnt == CW'(1))
            |=> state == ST_GAP3 || o_done;
    endproperty
    a_gap3: assert property (p_gap3) else $error("no gap3");
    c_start: cover property (@(posedge i_ref_clk)
        idx_rise && state == ST_WAIT_IDX);
    c_data: cover property (@(posedge i_ref_clk) state == ST_BODY && is_data);
    c_gap4: cover property (@(posedge i_ref_clk) state == ST_GAP4);
    c_done: cover property (@(posedge i_ref_clk) o_done);
endmodule : mtf_formatter
`default_nettype wire

// ### tb/mtf_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module mtf_drive_model #(
    parameter int PERIOD = 6000, // clocks per revolution
    parameter int PULSE = 8 // index pulse width in clocks
) (
    // clock
    input wire logic i_ref_clk,
    // write pins from the controller
    input wire logic i_write_gate,
    input wire logic i_write_data,
    // index pin to the controller
    output logic o_index
);
    int tick = 0; // rotation position, free running
    int phase = 0; // position inside a half-cell
    int ncell = 0; // half-cells since the gate rose
    int run = 0; // cycles of the current write
    int gate_len = 0; // length of the last write
    logic [15:0] cells = 16'h0000; // last sixteen half-cells
    logic [15:0] words[$]; // captured bytes as raw cells

    // index once per turn; the spindle ignores controller reset
    always @(posedge i_ref_clk) begin
        tick <= (tick == PERIOD - 1) ? 0 : tick + 1;
    end
    assign o_index = (tick >= PERIOD - PULSE);

    // sample inside each half-cell of the shifted stream; raw cells
    // are kept so that a dropped clock stays visible to the decoder
    always @(posedge i_ref_clk) begin
        if (!i_write_gate) begin
            phase <= 0;
            ncell <= 0;
        end else begin
            phase <= (phase + 1) % 4;
            if (phase == 3) begin
                cells <= {cells[14:0], i_write_data};
                ncell <= ncell + 1;
                if (ncell % 16 == 15) begin
                    words.push_back({cells[14:0], i_write_data});
                end
            end
        end
    end

    // measure how long the head was writing
    always @(posedge i_ref_clk) begin
        if (i_write_gate) begin
            run <= run + 1;
        end else begin
            if (run != 0) begin
                gate_len <= run;
            end
            run <= 0;
        end
    end
endmodule : mtf_drive_model
`default_nettype wire

// ### tb/mtf_track_formatter_bench.sv
`timescale 1ns/1ps
`default_nettype none
// compare two values and count the outcome
`define CHK(got, want) begin \
    compares++; \
    if ((got) !== (want)) begin \
        err_total++; \
        $display("wrong value at %0t: got %0h want %0h", $time, got, want); \
    end \
end
module mtf_track_formatter_bench import mtf_pkg::*; ();
    // shortened track so a revolution stays short
    localparam int G1 = 10; // below the floor, so 12 expected
    localparam int G2 = 4;
    localparam int G3 = 4;
    localparam int SY = 4;
    localparam int BD = 4; // one body is one 32-bit word
    localparam int NS = 2;
    localparam int PER = 6000; // clocks per revolution
    localparam int LIMIT = 70000; // under twelve revolutions
    // one ordinary format: id and first payload byte
    typedef struct packed {
        mtf_id_type id;
        logic [7:0] pay0;
    } mtf_row_type;
    localparam mtf_row_type ROWS [2] = '{
        '{32'h0102_0305, 8'h10}, '{32'hFFFF_0F00, 8'hF8}};

    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_start = 1'b0;
    mtf_id_type i_id = '0;
    logic i_pay_valid = 1'b0;
    logic [7:0] i_pay_data = 8'h00;
    logic o_busy, o_done, o_pay_ready, o_write_gate, o_write_data;
    logic index_pin; // driven by the drive model
    int err_total = 0;
    int compares = 0;
    int cyc = 0; // clocks since time zero
    int wait_n; // bounded wait counter
    logic [7:0] exp[$]; // expected bytes of one track
    logic mk[$]; // expected mark positions

    always #12.5 i_ref_clk = ~i_ref_clk;

    mtf_formatter #(.GAP1(G1), .GAP2(G2), .GAP3(G3), .SYNC(SY),
        .BODY(BD), .SECTORS(NS)) dut (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .i_start(i_start), .i_id(i_id), .o_busy(o_busy),
        .o_done(o_done), .i_pay_valid(i_pay_valid),
        .i_pay_data(i_pay_data), .o_pay_ready(o_pay_ready),
        .i_index(index_pin), .o_write_gate(o_write_gate),
        .o_write_data(o_write_data));

    mtf_drive_model #(.PERIOD(PER), .PULSE(8)) drv (
        .i_ref_clk(i_ref_clk), .i_write_gate(o_write_gate),
        .i_write_data(o_write_data), .o_index(index_pin));

    // hang guard: a hang counts as a mismatch
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            final_report();
        end
    end

    // check generator, msb first, one byte at a time
    function automatic logic [15:0] crc8(input logic [15:0] c,
                                         input logic [7:0] b);
        for (int k = 7; k >= 0; k--) begin
            c = (c[15] ^ b[k]) ? ({c[14:0], 1'b0} ^ 16'h1201)
                               : {c[14:0], 1'b0};
        end
        return c;
    endfunction : crc8

    task automatic put(input logic [7:0] b, input logic m);
        exp.push_back(b);
        mk.push_back(m);
    endtask : put

    // mark, kind, four bytes, then the check word high byte first
    task automatic field(input logic [7:0] kind, input logic [31:0] v);
        logic [15:0] c;
        c = crc8(crc8(16'hFFFF, 8'hA1), kind);
        put(8'hA1, 1'b1);
        put(kind, 1'b0);
        for (int k = 3; k >= 0; k--) begin
            c = crc8(c, v[8*k +: 8]);
            put(v[8*k +: 8], 1'b0);
        end
        put(c[15:8], 1'b0);
        put(c[7:0], 1'b0);
    endtask : field

    // whole track as it should leave the write pin
    task automatic build(input mtf_row_type r);
        logic [7:0] b;
        exp.delete();
        mk.delete();
        repeat (GAP1_MIN) put(GAP_FILL, 1'b0);
        for (int s = 0; s < NS; s++) begin
            // every id field is led in by its own sync bytes
            repeat (SY) put(SYNC_FILL, 1'b0);
            field(ID_MARK_BYTE, {r.id[31:8], 8'(s)});
            repeat (G2) put(GAP_FILL, 1'b0);
            repeat (SY) put(SYNC_FILL, 1'b0);
            b = r.pay0 + 8'(s * BD);
            field(DATA_MARK_BYTE, {b, b + 8'h01, b + 8'h02, b + 8'h03});
            repeat (G3) put(GAP_FILL, 1'b0);
        end
    endtask : build

    // decode captured cells; count clock cells that break encoding
    task automatic check_track();
        int v;
        logic p;
        logic m;
        logic [7:0] d;
        logic [7:0] e;
        p = 1'b0;
        `CHK(drv.words.size() >= exp.size(), 1'b1)
        foreach (drv.words[i]) begin
            v = 0;
            for (int k = 0; k < 8; k++) begin
                d[7-k] = drv.words[i][14-2*k];
                if ((i > 0 || k > 0) &&
                    drv.words[i][15-2*k] !== ~(p | d[7-k])) v++;
                p = d[7-k];
            end
            e = (i < exp.size()) ? exp[i] : GAP_FILL;
            m = (i < mk.size()) ? mk[i] : 1'b0;
            `CHK(d, e)
            `CHK(v, m ? 1 : 0)
        end
    endtask : check_track

    // one format: fill the buffer, start, refused restart, check
    task automatic run_format(input mtf_row_type r);
        int n;
        logic gl_ok;
        i_id = r.id;
        for (int j = 0; j < NS * BD; j++) begin
            i_pay_valid = 1'b1;
            i_pay_data = r.pay0 + 8'(j);
            @(negedge i_ref_clk);
        end
        `CHK(o_pay_ready, 1'b0)
        i_pay_data = 8'h5A; // offered while full, must be refused
        @(negedge i_ref_clk);
        i_pay_valid = 1'b0;
        build(r);
        drv.words.delete();
        i_start = 1'b1;
        @(negedge i_ref_clk);
        i_start = 1'b0;
        `CHK(o_busy, 1'b1)
        @(negedge i_ref_clk);
        i_start = 1'b1; // second start while busy is ignored
        @(negedge i_ref_clk);
        i_start = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 3 * PER) begin
            @(negedge i_ref_clk);
            n++;
        end
        `CHK(o_done, 1'b1)
        repeat (3) @(negedge i_ref_clk);
        `CHK(o_busy, 1'b0)
        gl_ok = (drv.gate_len >= PER - 2) && (drv.gate_len <= PER + 2);
        `CHK(gl_ok, 1'b1)
        `CHK(o_pay_ready, 1'b1)
        check_track();
    endtask : run_format

    task automatic final_report();
        $display("mismatches %0d, compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    initial begin
        // quiet outputs while reset is held
        repeat (2) @(negedge i_ref_clk);
        `CHK(o_write_gate, 1'b0)
        `CHK(o_busy, 1'b0)
        `CHK(o_done, 1'b0)
        `CHK(o_pay_ready, 1'b1)
        i_resetn = 1'b1;
        foreach (ROWS[i]) run_format(ROWS[i]);
        // reset in mid write must drop the gate at once
        i_start = 1'b1;
        @(negedge i_ref_clk);
        i_start = 1'b0;
        wait_n = 0;
        while (o_write_gate !== 1'b1 && wait_n < 2 * PER) begin
            @(negedge i_ref_clk);
            wait_n++;
        end
        repeat (100) @(negedge i_ref_clk);
        i_resetn = 1'b0;
        #1;
        `CHK(o_write_gate, 1'b0)
        `CHK(o_busy, 1'b0)
        @(negedge i_ref_clk);
        i_resetn = 1'b1;
        run_format(ROWS[0]);
        final_report();
    end
endmodule : mtf_track_formatter_bench
`default_nettype wire
